// *** inc/adbm_pkg.sv ***
// package: constants, register map and carriers for the address/data pin block
package adbm_pkg;
    localparam int unsigned ADBM_CLK_MHZ = 200;
    localparam int unsigned ADBM_LOCK_CYCLES = 4096;
    localparam logic [5:0] ADBM_OFF_CTRL = 6'h00;
    localparam logic [5:0] ADBM_OFF_ADDR = 6'h04;
    localparam logic [5:0] ADBM_OFF_WDATA = 6'h08;
    localparam logic [5:0] ADBM_OFF_FLAG_OUT = 6'h0C;
    localparam logic [5:0] ADBM_OFF_FLAG_OE = 6'h10;
    localparam logic [5:0] ADBM_OFF_STATUS = 6'h14;
    localparam logic [5:0] ADBM_OFF_RDATA = 6'h18;
    localparam int unsigned ADBM_CTRL_START = 0;
    localparam int unsigned ADBM_CTRL_WRITE = 1;
    localparam int unsigned ADBM_CTRL_WIDE = 2;
    localparam int unsigned ADBM_CTRL_PORT_EN = 3;
    localparam int unsigned ADBM_CTRL_FLAG_SEL = 20;
    localparam logic [31:0] ADBM_CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] ADBM_RESP_OKAY = 2'h0;
    localparam logic [1:0] ADBM_RESP_SLVERR = 2'h2;
    localparam logic [3:0] ADBM_PHASE_CYCLES = 4'h4;
    localparam logic [1:0] ADBM_BOOT_SPI_SLAVE = 2'h0;
    localparam logic [1:0] ADBM_BOOT_SPI_MASTER = 2'h1;
    localparam logic [1:0] ADBM_BOOT_PARALLEL = 2'h2;
    localparam logic [1:0] ADBM_CLK_RATIO_3 = 2'h0;
    localparam logic [1:0] ADBM_CLK_RATIO_16 = 2'h1;
    localparam logic [1:0] ADBM_CLK_RATIO_8 = 2'h2;
    localparam logic [4:0] ADBM_MULT_3 = 5'h03;
    localparam logic [4:0] ADBM_MULT_16 = 5'h10;
    localparam logic [4:0] ADBM_MULT_8 = 5'h08;

    typedef enum logic [1:0] {
        ADBM_BOOT_SLAVE, ADBM_BOOT_MASTER, ADBM_BOOT_EPROM, ADBM_BOOT_BAD
    } adbm_boot_type;

    // the pin group that faces the latch and memory
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic ale;
        logic [15:0] ad_out;
        logic [15:0] ad_oe;
    } adbm_pins_type;

    // decoded strap results
    typedef struct packed {
        adbm_boot_type boot;
        logic [4:0] clk_mult;
        logic clk_bad;
        logic lock_done;
    } adbm_straps_type;
endpackage

// *** hw/adbm_strap_decode.sv ***
// strap capture, boot and clock ratio decode, lock wait counter
`timescale 1ns/10ps
`default_nettype none
module adbm_strap_decode (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [1:0] boot_select_straps,
    input wire logic [1:0] clock_ratio_straps,
    output adbm_pkg::adbm_straps_type straps
);
    import adbm_pkg::*;
    logic [12:0] lock_cnt_reg;
    logic captured_reg;
    adbm_straps_type straps_reg;

    // straps are caught on the first enabled edge after release, never in reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            captured_reg <= 1'b0;
            straps_reg <= '0;
        end else if (clk_en && !captured_reg) begin
            captured_reg <= 1'b1;
            case (boot_select_straps)
                ADBM_BOOT_SPI_SLAVE: straps_reg.boot <= ADBM_BOOT_SLAVE;
                ADBM_BOOT_SPI_MASTER: straps_reg.boot <= ADBM_BOOT_MASTER;
                ADBM_BOOT_PARALLEL: straps_reg.boot <= ADBM_BOOT_EPROM;
                default: straps_reg.boot <= ADBM_BOOT_BAD;
            endcase
            // ratio is fixed here; later reprogramming belongs to software
            case (clock_ratio_straps)
                ADBM_CLK_RATIO_3: straps_reg.clk_mult <= ADBM_MULT_3;
                ADBM_CLK_RATIO_16: straps_reg.clk_mult <= ADBM_MULT_16;
                ADBM_CLK_RATIO_8: straps_reg.clk_mult <= ADBM_MULT_8;
                default: straps_reg.clk_bad <= 1'b1;
            endcase
        end else if (clk_en && !straps_reg.lock_done) begin
            if (lock_cnt_reg == 13'(ADBM_LOCK_CYCLES - 1)) begin
                straps_reg.lock_done <= 1'b1;
            end
        end
    end

    // lock wait counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_cnt_reg <= 13'h0000;
        end else if (clk_en && captured_reg && !straps_reg.lock_done) begin
            lock_cnt_reg <= lock_cnt_reg + 13'h0001;
        end
    end

    assign straps = straps_reg;

    property p_lock_time;
        @(posedge clk) disable iff (!resetn)
        $rose(straps_reg.lock_done) |-> lock_cnt_reg == 13'(ADBM_LOCK_CYCLES);
    endproperty
    a_lock_time: assert property (p_lock_time)
        else $error("lock wait length wrong");

    property p_ratio_hold;
        @(posedge clk) disable iff (!resetn)
        captured_reg && $past(captured_reg) |-> $stable(straps_reg.clk_mult);
    endproperty
    a_ratio_hold: assert property (p_ratio_hold)
        else $error("ratio changed after capture");
endmodule // adbm_strap_decode
`default_nettype wire

// *** hw/adbm_ad_bus_mux.sv ***
// multiplexed address/data port, flag pin use and strap results
//
// Overview of operation
// - strobes always driven, never high impedance
// - flags only with control bit 20, port off
// - pins 0-7 to flags 8-15, swapped
// - boot straps decode slave, master, eprom
// - ratio straps give 3, 16, 8
// - 8-bit: high address then data, low address
// - 16-bit: address 15-0 then data 15-0
// - wait 4096 clocks for lock after reset
// - ratio straps taken once, on first edge after reset
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module adbm_ad_bus_mux (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] muxed_addr_data_pins_in,
    output logic [15:0] muxed_addr_data_pins_out,
    output logic [15:0] muxed_addr_data_pins_oe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic addr_latch_strobe,
    input wire logic [1:0] boot_select_straps,
    input wire logic [1:0] clock_ratio_straps
);
    import adbm_pkg::*;
    typedef enum logic [2:0] {ADBM_IDLE, ADBM_ADDR, ADBM_DATA} adbm_state_type;
    adbm_state_type state_reg;
    logic [31:0] system_control_reg, addr_reg, wdata_reg;
    logic [15:0] flag_out_reg, flag_oe_reg, rdata_reg;
    logic [3:0] phase_cnt_reg;
    logic [5:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    adbm_pins_type pins_reg;
    adbm_straps_type straps;
    logic flag_mode, wide, do_write, start_req;
    logic [15:0] flags_in;

    adbm_strap_decode u_straps (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .boot_select_straps(boot_select_straps),
        .clock_ratio_straps(clock_ratio_straps),
        .straps(straps)
    );

    assign flag_mode = system_control_reg[ADBM_CTRL_FLAG_SEL] &&
                       !system_control_reg[ADBM_CTRL_PORT_EN];
    assign wide = system_control_reg[ADBM_CTRL_WIDE];
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign start_req = do_write && aw_addr_reg == ADBM_OFF_CTRL &&
                       w_data_reg[ADBM_CTRL_START];

    // pin-to-flag swap of the two byte halves
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_swap
            assign flags_in[gi + 8] = muxed_addr_data_pins_in[gi];
            assign flags_in[gi] = muxed_addr_data_pins_in[gi + 8];
        end
    endgenerate

    // write channels taken in either order, held until the response goes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_addr_reg <= 6'h00;
            w_data_reg <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ADBM_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data_reg <= s_axi_wdata;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_reg <= ADBM_OFF_FLAG_OE &&
                    aw_addr_reg[1:0] == 2'h0) ? ADBM_RESP_OKAY
                    : ADBM_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // control and data registers; byte strobes are ignored, full words only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            system_control_reg <= ADBM_CTRL_RESET;
            addr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            flag_out_reg <= 16'h0000;
            flag_oe_reg <= 16'h0000;
        end else if (clk_en && do_write) begin
            case (aw_addr_reg)
                ADBM_OFF_CTRL: system_control_reg <= w_data_reg &
                    ~(32'h1 << ADBM_CTRL_START);
                ADBM_OFF_ADDR: addr_reg <= w_data_reg;
                ADBM_OFF_WDATA: wdata_reg <= w_data_reg;
                ADBM_OFF_FLAG_OUT: flag_out_reg <= w_data_reg[15:0];
                ADBM_OFF_FLAG_OE: flag_oe_reg <= w_data_reg[15:0];
                default: ;
            endcase
        end
    end

    // transfer sequencer: address phase with strobe high, then data phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ADBM_IDLE;
            phase_cnt_reg <= 4'h0;
            rdata_reg <= 16'h0000;
        end else if (clk_en) begin
            case (state_reg)
                ADBM_IDLE: begin
                    phase_cnt_reg <= 4'h0;
                    // no transfers before lock or while pins serve as flags
                    if (start_req && straps.lock_done && !flag_mode &&
                        system_control_reg[ADBM_CTRL_PORT_EN]) begin
                        state_reg <= ADBM_ADDR;
                    end
                end
                ADBM_ADDR: begin
                    phase_cnt_reg <= phase_cnt_reg + 4'h1;
                    if (phase_cnt_reg == ADBM_PHASE_CYCLES - 4'h1) begin
                        phase_cnt_reg <= 4'h0;
                        state_reg <= ADBM_DATA;
                    end
                end
                ADBM_DATA: begin
                    phase_cnt_reg <= phase_cnt_reg + 4'h1;
                    if (phase_cnt_reg == ADBM_PHASE_CYCLES - 4'h1) begin
                        rdata_reg <= muxed_addr_data_pins_in;
                        state_reg <= ADBM_IDLE;
                    end
                end
                default: state_reg <= ADBM_IDLE;
            endcase
        end
    end

    // pin drivers, all from flops; strobes never released
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins_reg.rd_n <= 1'b1;
            pins_reg.wr_n <= 1'b1;
            pins_reg.ale <= 1'b0;
            pins_reg.ad_out <= 16'h0000;
            pins_reg.ad_oe <= 16'h0000;
        end else if (clk_en) begin
            pins_reg.rd_n <= 1'b1;
            pins_reg.wr_n <= 1'b1;
            pins_reg.ale <= 1'b0;
            pins_reg.ad_oe <= 16'h0000;
            pins_reg.ad_out <= 16'h0000;
            if (flag_mode) begin
                pins_reg.ad_out <= {flag_out_reg[7:0], flag_out_reg[15:8]};
                pins_reg.ad_oe <= {flag_oe_reg[7:0], flag_oe_reg[15:8]};
            end else if (state_reg == ADBM_ADDR) begin
                pins_reg.ale <= 1'b1;
                pins_reg.ad_oe <= 16'hFFFF;
                if (wide) begin
                    pins_reg.ad_out <= addr_reg[15:0];
                end else begin
                    pins_reg.ad_out <= addr_reg[23:8];
                end
            end else if (state_reg == ADBM_DATA) begin
                pins_reg.rd_n <= system_control_reg[ADBM_CTRL_WRITE];
                pins_reg.wr_n <= !system_control_reg[ADBM_CTRL_WRITE];
                if (wide) begin
                    pins_reg.ad_out <= wdata_reg[15:0];
                    pins_reg.ad_oe <=
                        {16{system_control_reg[ADBM_CTRL_WRITE]}};
                end else begin
                    pins_reg.ad_out <= {addr_reg[7:0],
                        wdata_reg[7:0]};
                    pins_reg.ad_oe <= {8'hFF,
                        {8{system_control_reg[ADBM_CTRL_WRITE]}}};
                end
            end
        end
    end

    // read channel, answer one enabled cycle after the address is taken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ADBM_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= ADBM_RESP_OKAY;
                case (s_axi_araddr)
                    ADBM_OFF_CTRL: s_axi_rdata <= system_control_reg;
                    ADBM_OFF_ADDR: s_axi_rdata <= addr_reg;
                    ADBM_OFF_WDATA: s_axi_rdata <= wdata_reg;
                    ADBM_OFF_FLAG_OUT: s_axi_rdata <= {16'h0000, flag_out_reg};
                    ADBM_OFF_FLAG_OE: s_axi_rdata <= {16'h0000, flag_oe_reg};
                    ADBM_OFF_STATUS: s_axi_rdata <= {16'h0000, flags_in};
                    // exactly 32 bits: ratio result on top, boot at 25:24
                    ADBM_OFF_RDATA: s_axi_rdata <= {straps.clk_bad,
                        straps.clk_mult, straps.boot, 5'h00,
                        straps.lock_done, state_reg != ADBM_IDLE,
                        flag_mode, rdata_reg};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= ADBM_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    assign read_strobe_n = pins_reg.rd_n;
    assign write_strobe_n = pins_reg.wr_n;
    assign addr_latch_strobe = pins_reg.ale;
    assign muxed_addr_data_pins_out = pins_reg.ad_out;
    assign muxed_addr_data_pins_oe = pins_reg.ad_oe;

    property p_strobe_known;
        @(posedge clk) disable iff (!resetn)
        !(pins_reg.rd_n == 1'b0 && pins_reg.wr_n == 1'b0);
    endproperty
    a_strobe_known: assert property (p_strobe_known)
        else $error("both strobes low");

    property p_flag_gate;
        @(posedge clk) disable iff (!resetn)
        clk_en && !flag_mode && state_reg == ADBM_IDLE |=>
            pins_reg.ad_oe == 16'h0000 || flag_mode;
    endproperty
    a_flag_gate: assert property (p_flag_gate)
        else $error("pins driven outside flag or port use");

    property p_flag_swap;
        @(posedge clk) disable iff (!resetn)
        clk_en && flag_mode |=>
            pins_reg.ad_out[7:0] == $past(flag_out_reg[15:8]);
    endproperty
    a_flag_swap: assert property (p_flag_swap)
        else $error("flag mapping wrong");

    property p_addr8;
        @(posedge clk) disable iff (!resetn)
        pins_reg.ale && !wide && !$past(flag_mode) |->
            pins_reg.ad_out == addr_reg[23:8];
    endproperty
    a_addr8: assert property (p_addr8)
        else $error("8-bit address phase wrong");

    property p_addr16;
        @(posedge clk) disable iff (!resetn)
        pins_reg.ale && wide |-> pins_reg.ad_out == addr_reg[15:0];
    endproperty
    a_addr16: assert property (p_addr16)
        else $error("16-bit address phase wrong");

    property p_ale_len;
        @(posedge clk) disable iff (!resetn)
        clk_en && $rose(pins_reg.ale) |-> pins_reg.ale[*4] ##1 !pins_reg.ale;
    endproperty
    a_ale_len: assert property (p_ale_len)
        else $error("address phase length wrong");

    c_read8: cover property (@(posedge clk) disable iff (!resetn)
        $fell(pins_reg.rd_n) && !wide);
    c_write16: cover property (@(posedge clk) disable iff (!resetn)
        $fell(pins_reg.wr_n) && wide);
    c_flags: cover property (@(posedge clk) disable iff (!resetn)
        $rose(flag_mode));
endmodule // adbm_ad_bus_mux
`default_nettype wire

// *** sim/adbm_mem_model.sv ***
// behavioural external address latch and 8/16-bit memory on the muxed pins
`timescale 1ns/10ps
`default_nettype none
module adbm_mem_model (
    input wire logic clk,
    input wire logic [15:0] pins,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic addr_latch_strobe,
    input wire logic wide,
    output logic [15:0] mem_out,
    output logic [15:0] mem_oe,
    output logic [15:0] latched,
    output logic [15:0] wr_word
);
    logic [23:0] full_addr;
    // latch tracks the pins while the strobe is high, holds after its fall
    always @(posedge clk) begin
        if (addr_latch_strobe) begin
            latched <= pins;
        end
        if (!write_strobe_n) begin
            wr_word <= pins;
        end
    end
    // 8-bit mode: low address byte still rides on pins 15-8 in data phase
    assign full_addr = wide ? {8'h00, latched} : {latched, pins[15:8]};
    assign mem_out = {full_addr[15:8] ^ 8'h5A,
        full_addr[7:0] ^ full_addr[23:16]};
    // released lines fall back to the pin pull-ups in the bench
    assign mem_oe = read_strobe_n ? 16'h0000 : (wide ? 16'hFFFF : 16'h00FF);
endmodule // adbm_mem_model
`default_nettype wire

// *** sim/ad_bus_mux_and_straps_tb.sv ***
// self-checking bench for the muxed address/data port and strap decode
`timescale 1ns/10ps
`default_nettype none
module ad_bus_mux_and_straps_tb;
    import adbm_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, wide_mode = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, seed = 32'h0201CF8C, s_axi_rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, boot_s = 2'h0, ratio_s = 2'h0;
    logic [15:0] pins_out, pins_oe, pin_wire, mem_out, mem_oe;
    logic [15:0] latched, wr_word, ext_oe = 16'h0, ext_val = 16'h0;
    logic rd_n, wr_n, ale;
    int n_mismatch = 0;
    int comparisons = 0;

    always #2.5 clk = ~clk;
    // pins have pull-ups: an undriven line reads high
    assign pin_wire = (pins_oe & pins_out) | (~pins_oe & mem_oe & mem_out)
        | (~pins_oe & ~mem_oe & (~ext_oe | ext_val));

    adbm_ad_bus_mux dut (.clk(clk), .resetn(resetn), .clk_en(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .muxed_addr_data_pins_in(pin_wire),
        .muxed_addr_data_pins_out(pins_out),
        .muxed_addr_data_pins_oe(pins_oe), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .addr_latch_strobe(ale),
        .boot_select_straps(boot_s), .clock_ratio_straps(ratio_s));

    adbm_mem_model mem (.clk(clk), .pins(pin_wire), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .addr_latch_strobe(ale), .wide(wide_mode),
        .mem_out(mem_out), .mem_oe(mem_oe), .latched(latched),
        .wr_word(wr_word));

    // xorshift source, fixed seed so every run is the same
    task automatic rnd(output logic [31:0] v);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        v = seed;
    endtask

    // reference memory content, independent of the model's wiring
    function automatic logic [15:0] mem_word(input logic [23:0] a);
        return {a[15:8] ^ 8'h5A, a[7:0] ^ a[23:16]};
    endfunction

    // expected {bad, multiplier} for each ratio strap code
    function automatic logic [31:0] ratio_word(input logic [1:0] s);
        case (s)
            ADBM_CLK_RATIO_3: return {27'h0, ADBM_MULT_3};
            ADBM_CLK_RATIO_16: return {27'h0, ADBM_MULT_16};
            ADBM_CLK_RATIO_8: return {27'h0, ADBM_MULT_8};
            default: return 32'h0000_0020;
        endcase
    endfunction

    function automatic logic [15:0] swap(input logic [15:0] v);
        return {v[7:0], v[15:8]};
    endfunction

    task automatic complete_run();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic give_up(input string what);
        n_mismatch++;
        $display("Error at %0t: no answer on %s", $time, what);
        complete_run();
    endtask

    // one write; address and data are released each at its own handshake
    task automatic axi_write(input logic [5:0] a, input logic [31:0] d,
        output logic [1:0] resp);
        logic aw_on;
        logic w_on;
        logic [31:0] r;
        rnd(r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= r[3:0];
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_on = 1'b1;
        w_on = 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            if (aw_on && awready === 1'b1) begin
                aw_on = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_on && wready === 1'b1) begin
                w_on = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        give_up("write");
    endtask

    task automatic axi_read(input logic [5:0] a, output logic [31:0] d,
        output logic [1:0] resp);
        logic ar_on;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar_on = 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            if (ar_on && arready === 1'b1) begin
                ar_on = 1'b0;
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) begin
                d = s_axi_rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        give_up("read");
    endtask

    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        check({29'h0, rd_n, wr_n, ale}, 32'h6, "strobes in reset");
        resetn <= 1'b1;
    endtask

    initial begin
        logic [31:0] r;
        logic [31:0] a;
        logic [31:0] d;
        logic [1:0] resp;
        // every boot code, including the reserved one, across fresh resets
        for (int k = 0; k < 4; k++) begin
            rnd(r);
            boot_s <= k[1:0];
            ratio_s <= r[1:0];
            do_reset();
            repeat (4) @(posedge clk);
            // straps moving after capture must not reach the result
            ratio_s <= ~ratio_s;
            axi_read(ADBM_OFF_RDATA, r, resp);
            check({30'h0, r[25:24]}, k, "boot decode");
            check({26'h0, r[31:26]}, ratio_word(~ratio_s),
                "ratio decode");
            check({31'h0, r[18]}, 32'h0, "early lock");
        end
        boot_s <= ADBM_BOOT_PARALLEL;
        do_reset();
        repeat (3990) @(posedge clk);
        axi_read(ADBM_OFF_RDATA, r, resp);
        check({31'h0, r[18]}, 32'h0, "lock too soon");
        repeat (200) @(posedge clk);
        axi_read(ADBM_OFF_RDATA, r, resp);
        check({31'h0, r[18]}, 32'h1, "lock missing");
        // a start is only taken once the port is already on
        axi_write(ADBM_OFF_CTRL, 32'h0000_0008, resp);
        // read and write in both widths: bit 0 write, bit 1 wide
        for (int k = 0; k < 4; k++) begin
            rnd(a);
            rnd(d);
            wide_mode <= k[1];
            axi_write(ADBM_OFF_ADDR, {8'h00, a[23:0]}, resp);
            axi_write(ADBM_OFF_WDATA, {16'h0, d[15:0]}, resp);
            axi_write(ADBM_OFF_CTRL, {28'h0, 1'b1, k[1], k[0], 1'b1}, resp);
            r = 32'h0002_0000;
            for (int i = 0; i < 100 && r[17] !== 1'b0; i++) begin
                axi_read(ADBM_OFF_RDATA, r, resp);
            end
            if (r[17] !== 1'b0) begin
                give_up("busy");
            end
            check(latched, k[1] ? a[15:0] : a[23:8],
                "address phase");
            if (k[0]) begin
                check(wr_word, k[1] ? d[15:0] : {a[7:0], d[7:0]},
                    "write data phase");
            end else if (k[1]) begin
                check(r[15:0], mem_word({8'h00, a[15:0]}), "read 16");
            end else begin
                check(r[7:0], mem_word(a[23:0]) & 16'h00FF, "read 8");
            end
        end
        // flag use: bit 20 with the port off, pin halves swapped
        rnd(a);
        rnd(d);
        axi_write(ADBM_OFF_CTRL, 32'h0010_0000, resp);
        axi_write(ADBM_OFF_FLAG_OUT, {16'h0, a[15:0]}, resp);
        axi_write(ADBM_OFF_FLAG_OE, {16'h0, d[15:0]}, resp);
        repeat (2) @(posedge clk);
        check(pins_oe, swap(d[15:0]), "flag enables");
        check(pins_out & pins_oe, swap(a[15:0] & d[15:0]), "flag out");
        rnd(r);
        ext_val <= r[15:0];
        ext_oe <= ~swap(d[15:0]);
        axi_read(ADBM_OFF_STATUS, r, resp);
        a[15:0] = (swap(d[15:0]) & swap(a[15:0])) | (~swap(d[15:0]) & ext_val);
        check(r[15:0], swap(a[15:0]), "flag in");
        axi_read(ADBM_OFF_RDATA, r, resp);
        check({31'h0, r[16]}, 32'h1, "flag mode on");
        ext_oe <= 16'h0000;
        axi_write(ADBM_OFF_CTRL, 32'h0010_0008, resp);
        axi_read(ADBM_OFF_RDATA, r, resp);
        check({31'h0, r[16]}, 32'h0, "flag mode with port");
        // unmapped places and the read-only status write answer with an error
        axi_read(6'h1C, r, resp);
        check({30'h0, resp}, ADBM_RESP_SLVERR, "unmapped read");
        axi_write(6'h14, 32'h0, resp);
        check({30'h0, resp}, ADBM_RESP_SLVERR, "read-only write");
        complete_run();
    end
endmodule // ad_bus_mux_and_straps_tb
`default_nettype wire
